// File: include/cdprs_pkg.sv
// Package: register map, reset values, codes and state records of the power/reset/sync control
package cdprs_pkg;
   localparam int unsigned NUM_PECL = 4;
   localparam int unsigned NUM_LVDS = 4;

   // Register offsets on the serial configuration port
   localparam logic [12:0] OFS_PORT_CFG  = 13'h0000;
   localparam logic [12:0] OFS_PLL_PD    = 13'h000A;
   localparam logic [12:0] OFS_PECL_PD0  = 13'h003C;
   localparam logic [12:0] OFS_LVDS_PD0  = 13'h0040;
   localparam logic [12:0] OFS_FUNC_SYNC = 13'h0058;
   localparam logic [12:0] OFS_UPDATE    = 13'h005A;

   // Field positions
   localparam int unsigned BIT_BIDIR     = 7;
   localparam int unsigned BIT_SOFT_RST  = 5;
   localparam int unsigned LSB_PLL_PD    = 0;
   localparam int unsigned LSB_FPIN_MODE = 5;
   localparam int unsigned BIT_DIST_PD   = 3;
   localparam int unsigned BIT_SOFT_SYNC = 2;
   localparam int unsigned BIT_WIN_SEL   = 1;
   localparam int unsigned BIT_MCS_EN    = 0;
   localparam int unsigned BIT_UPDATE    = 0;
   localparam int unsigned LSB_PECL_MODE = 0;
   localparam int unsigned BIT_LVDS_PD   = 0;

   // Field codes
   localparam logic [1:0] FPIN_RESET   = 2'h0;
   localparam logic [1:0] FPIN_SYNC    = 2'h1;
   localparam logic [1:0] FPIN_SLEEP   = 2'h2;
   localparam logic [1:0] PLL_PD_ASYNC = 2'h1;
   localparam logic [1:0] PLL_PD_SYNC  = 2'h3;
   localparam logic [1:0] PECL_SAFE    = 2'h2;

   // Values after reset
   localparam logic [7:0] RST_PORT_CFG  = 8'h00;
   localparam logic [7:0] RST_PLL_PD    = 8'h00;
   localparam logic [7:0] RST_FUNC_SYNC = 8'h00;
   localparam logic [7:0] RST_PECL_PD   = 8'h00;
   localparam logic [7:0] RST_LVDS_PD   = 8'h00;

   // Slow-edge coincidence tolerance, whole fast clock cycles
   localparam logic [1:0] TOL_WIDE   = 2'h1;
   localparam logic [1:0] TOL_NARROW = 2'h0;

   // Serial frame bit counter values at the last bit
   localparam logic [3:0] INSTR_LAST = 4'hF;
   localparam logic [3:0] BYTE_LAST  = 4'h7;

   typedef enum logic [1:0] {SP_INSTR = 2'b00, SP_DATA = 2'b01} cdprs_sp_e;
   typedef enum logic [1:0] {PS_RUN = 2'b00, PS_SLEEP = 2'b01, PS_HRST = 2'b11} cdprs_ps_e;

   typedef struct packed {
      logic        en;
      logic [12:0] addr;
      logic [7:0]  data;
   } cdprs_wr_s;

   typedef struct packed {
      logic [7:0]                port_cfg;
      logic [7:0]                pll_pd;
      logic [7:0]                func_sync;
      logic [NUM_PECL-1:0][7:0]  pecl_pd;
      logic [NUM_LVDS-1:0][7:0]  lvds_pd;
   } cdprs_cfg_s;

   localparam cdprs_cfg_s CFG_DEFAULT = '{port_cfg: RST_PORT_CFG, pll_pd: RST_PLL_PD,
                                          func_sync: RST_FUNC_SYNC,
                                          pecl_pd: {NUM_PECL{RST_PECL_PD}},
                                          lvds_pd: {NUM_LVDS{RST_LVDS_PD}}};

   typedef struct packed {
      logic                      pll_pd;
      logic                      dist_pd;
      logic                      clocks_off;
      logic                      dividers_off;
      logic                      sync_hold;
      logic [NUM_LVDS-1:0]       lvds_off;
      logic [NUM_PECL-1:0][1:0]  pecl_mode;
   } cdprs_pwr_s;

   typedef struct packed {
      cdprs_sp_e   st;
      logic        sclk_d;
      logic [3:0]  bits;
      logic [15:0] sh;
      logic        rd;
      logic        stream;
      logic [1:0]  left;
      logic [12:0] addr;
      logic [7:0]  tx;
      logic        sdo;
      logic        sdo_oe;
      logic        sdio_oe;
      cdprs_wr_s   wr;
   } cdprs_sp_s;

   localparam cdprs_sp_s SP_RESET = '{st: SP_INSTR, default: '0};

   typedef struct packed {
      cdprs_ps_e   ps;
      cdprs_cfg_s  shadow;
      cdprs_cfg_s  active;
      logic        pll_pd_st;
      logic        pll_pend;
      logic        ref_d;
      logic        fb_d;
      logic        ref_wait;
      logic        fb_wait;
      logic [1:0]  ref_age;
      logic [1:0]  fb_age;
      logic        oos;
      cdprs_pwr_s  pwr;
      logic        status;
      logic        status_oe;
   } cdprs_top_s;

   localparam cdprs_top_s TOP_RESET = '{ps: PS_RUN, shadow: CFG_DEFAULT, active: CFG_DEFAULT,
                                        pwr: '0, default: '0};
endpackage

// File: src/cdprs_serial_port.sv
// Serial configuration port slave: 16-bit instruction, 1-3 bytes or streaming writes (a read with length code 11 takes 4 bytes), MSB first
`timescale 1ns/10ps
`default_nettype none
module cdprs_serial_port (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Serial pins, sampled on the system clock
   input  wire logic                 sclk,
   input  wire logic                 csb_n,
   input  wire logic                 sdio_in,
   input  wire logic                 bidir_mode,
   // Register access
   output var  cdprs_pkg::cdprs_wr_s wr,
   output logic [12:0]               rd_addr,
   input  wire logic [7:0]           rd_data,
   // Read-back drive
   output logic                      sdo_out,
   output logic                      sdo_oe,
   output logic                      sdio_out,
   output logic                      sdio_oe
);
   import cdprs_pkg::*;

   cdprs_sp_s s_r;
   cdprs_sp_s s_nxt;
   logic      rise;
   logic      fall;

   assign rise = sclk & ~s_r.sclk_d;
   assign fall = ~sclk & s_r.sclk_d;

   // Shift engine; a stall with CSB high on a byte boundary simply waits
   always_comb begin
      s_nxt        = s_r;
      s_nxt.wr.en  = 1'b0;
      s_nxt.sclk_d = sclk;
      if (csb_n) begin
         s_nxt.sdo_oe  = 1'b0;
         s_nxt.sdio_oe = 1'b0;
         // Raising CSB mid-byte aborts the cycle and drops the partial byte
         if (s_r.bits != 4'h0) begin
            s_nxt.st   = SP_INSTR;
            s_nxt.bits = 4'h0;
         end
      end else if (rise) begin
         s_nxt.sh   = {s_r.sh[14:0], sdio_in};
         s_nxt.bits = s_r.bits + 4'h1;
         unique case (s_r.st)
            SP_INSTR: begin
               if (s_r.bits == INSTR_LAST) begin
                  s_nxt.bits   = 4'h0;
                  s_nxt.st     = SP_DATA;
                  s_nxt.rd     = s_r.sh[14];
                  s_nxt.left   = s_r.sh[13:12];
                  s_nxt.stream = (&s_r.sh[13:12]) & ~s_r.sh[14];
                  s_nxt.addr   = {s_r.sh[11:0], sdio_in};
               end
            end
            SP_DATA: begin
               if (s_r.bits == BYTE_LAST) begin
                  s_nxt.bits = 4'h0;
                  if (!s_r.rd) begin
                     s_nxt.wr = '{en: 1'b1, addr: s_r.addr, data: {s_r.sh[6:0], sdio_in}};
                  end
                  // MSB-first streaming walks the address downward
                  s_nxt.addr = s_r.addr - 13'h0001;
                  if (!s_r.stream) begin
                     if (s_r.left == 2'h0) begin
                        s_nxt.st      = SP_INSTR;
                        s_nxt.sdo_oe  = 1'b0;
                        s_nxt.sdio_oe = 1'b0;
                     end else begin
                        s_nxt.left = s_r.left - 2'h1;
                     end
                  end
               end
            end
         endcase
      end else if (fall && s_r.st == SP_DATA && s_r.rd) begin
         // Read data changes on the falling edge, fresh byte fetched at byte start
         s_nxt.sdo     = (s_r.bits == 4'h0) ? rd_data[7] : s_r.tx[7];
         s_nxt.tx      = (s_r.bits == 4'h0) ? {rd_data[6:0], 1'b0} : {s_r.tx[6:0], 1'b0};
         s_nxt.sdo_oe  = ~bidir_mode;
         s_nxt.sdio_oe = bidir_mode;
      end
   end

   // State register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= SP_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wr       = s_r.wr;
   assign rd_addr  = s_r.addr;
   assign sdo_out  = s_r.sdo;
   assign sdio_out = s_r.sdo;
   assign sdo_oe   = s_r.sdo_oe;
   assign sdio_oe  = s_r.sdio_oe;
endmodule
`default_nettype wire

// File: src/cdprs_top.sv
// Power-down, reset and output sync control of an eight-output clock distribution device
// Notes on behaviour
// - Sleep-pin mode: pin low holds chip asleep
// - Wake keeps registers, including writes while asleep
// - Sleep stops PLL, clocks, dividers; PECL safe
// - PLL field: 00,10 normal; 01 async; 11 sync
// - Async PLL power-down acts on update
// - Sync PLL power-down waits next charge-pump event
// - Distribution power-down bit removes distribution bias
// - PECL modes 00 normal, 10 protected, 11 not
// - Each output has its own power-down
// - Power-on loads every register default
// - Function mode 00: pin low hard resets
// - Soft reset restores defaults except its register
// - Soft-reset bit stays until host clears it
// - Function mode 01: pin low holds sync state
// - Soft sync bit is inverted sync input
// - Multichip enable drives sync flag on status
// - Window bit picks slow-edge coincidence tolerance
// - Writes shadowed; self-clearing update bit applies them, except port config, which acts at once
`timescale 1ns/10ps
`default_nettype none
module cdprs_top (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // Multi-purpose pin and PLL event
   input  wire logic               func_pin,
   input  wire logic               cp_event,
   // Slow clocks for multichip coincidence check
   input  wire logic               slow_ref,
   input  wire logic               slow_fb,
   // Serial configuration port
   input  wire logic               sclk,
   input  wire logic               csb_n,
   input  wire logic               sdio_in,
   output logic                    sdio_out,
   output logic                    sdio_oe,
   output logic                    sdo_out,
   output logic                    sdo_oe,
   // Power and sync controls toward the analog section
   output var  cdprs_pkg::cdprs_pwr_s pwr,
   // Status pin
   output logic                    status_out,
   output logic                    status_oe
);
   import cdprs_pkg::*;

   cdprs_top_s s_r;
   cdprs_top_s s_nxt;
   cdprs_wr_s  wr;
   logic [12:0] rd_addr;
   logic [7:0]  rd_data;
   logic        sleep_c;
   logic        hrst_c;
   logic [NUM_LVDS-1:0]      lvds_off_c;
   logic [NUM_PECL-1:0][1:0] pecl_mode_c;
   logic [1:0]  fmode;
   logic        soft_rst;
   logic        mcs_en;
   logic        upd;
   logic        ref_rise;
   logic        fb_rise;
   logic [1:0]  tol;

   // Writes only ever touch the shadow copy
   function automatic cdprs_cfg_s shadow_write(input cdprs_cfg_s c, input cdprs_wr_s w);
      cdprs_cfg_s r;
      r = c;
      if (w.addr == OFS_PORT_CFG) begin
         r.port_cfg = w.data;
      end else if (w.addr == OFS_PLL_PD) begin
         r.pll_pd = w.data;
      end else if (w.addr == OFS_FUNC_SYNC) begin
         r.func_sync = w.data;
      end else if (w.addr[12:2] == OFS_PECL_PD0[12:2]) begin
         r.pecl_pd[w.addr[1:0]] = w.data;
      end else if (w.addr[12:2] == OFS_LVDS_PD0[12:2]) begin
         r.lvds_pd[w.addr[1:0]] = w.data;
      end
      return r;
   endfunction

   // Read-back shows the shadow, not the active copy; unmapped and update read zero
   function automatic logic [7:0] shadow_read(input cdprs_cfg_s c, input logic [12:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == OFS_PORT_CFG) begin
         d = c.port_cfg;
      end else if (a == OFS_PLL_PD) begin
         d = c.pll_pd;
      end else if (a == OFS_FUNC_SYNC) begin
         d = c.func_sync;
      end else if (a[12:2] == OFS_PECL_PD0[12:2]) begin
         d = c.pecl_pd[a[1:0]];
      end else if (a[12:2] == OFS_LVDS_PD0[12:2]) begin
         d = c.lvds_pd[a[1:0]];
      end
      return d;
   endfunction

   // Port stays live in every state, so writes during sleep land too
   cdprs_serial_port u_port (
      .clock      (clock),
      .rst        (rst),
      .sclk       (sclk),
      .csb_n      (csb_n),
      .sdio_in    (sdio_in),
      .bidir_mode (s_r.shadow.port_cfg[BIT_BIDIR]),
      .wr         (wr),
      .rd_addr    (rd_addr),
      .rd_data    (rd_data),
      .sdo_out    (sdo_out),
      .sdo_oe     (sdo_oe),
      .sdio_out   (sdio_out),
      .sdio_oe    (sdio_oe)
   );

   assign rd_data  = shadow_read(s_r.shadow, rd_addr);
   assign fmode    = s_r.active.func_sync[LSB_FPIN_MODE +: 2];
   assign soft_rst = s_r.shadow.port_cfg[BIT_SOFT_RST];
   assign mcs_en   = s_r.active.func_sync[BIT_MCS_EN];
   assign upd      = wr.en && (wr.addr == OFS_UPDATE) && wr.data[BIT_UPDATE];
   assign ref_rise = slow_ref & ~s_r.ref_d;
   assign fb_rise  = slow_fb & ~s_r.fb_d;
   // Narrow window only accepts edges in the same fast clock cycle
   assign tol = s_r.active.func_sync[BIT_WIN_SEL] ? TOL_NARROW : TOL_WIDE;

   // Decode of the power state
   always_comb begin
      sleep_c = 1'b0;
      hrst_c  = 1'b0;
      unique case (s_r.ps)
         PS_RUN:   begin
            sleep_c = 1'b0;
         end
         PS_SLEEP: begin
            sleep_c = 1'b1;
         end
         PS_HRST:  begin
            hrst_c = 1'b1;
         end
         default:  begin
            hrst_c = 1'b1;
         end
      endcase
   end

   // Per-output power-down; PECL drops to safe-off bias while asleep
   for (genvar i = 0; i < NUM_PECL; i++) begin : g_pecl
      assign pecl_mode_c[i] = sleep_c ? PECL_SAFE :
                              s_r.active.pecl_pd[i][LSB_PECL_MODE +: 2];
   end
   for (genvar i = 0; i < NUM_LVDS; i++) begin : g_lvds
      // Load type plays no part: the bit alone turns the driver off
      assign lvds_off_c[i] = sleep_c | hrst_c | s_r.active.lvds_pd[i][BIT_LVDS_PD];
   end

   // Next-state logic: shadow, update, PLL gating, resets, power state, detector
   always_comb begin
      logic [7:0] keep_port;
      keep_port = s_r.shadow.port_cfg;
      s_nxt = s_r;
      if (wr.en) begin
         s_nxt.shadow = shadow_write(s_r.shadow, wr);
      end
      if (upd) begin
         s_nxt.active = s_r.shadow;
         case (s_r.shadow.pll_pd[LSB_PLL_PD +: 2])
            PLL_PD_ASYNC: begin
               s_nxt.pll_pd_st = 1'b1;
               s_nxt.pll_pend  = 1'b0;
            end
            PLL_PD_SYNC: begin
               s_nxt.pll_pend = ~s_r.pll_pd_st;
            end
            default: begin
               s_nxt.pll_pd_st = 1'b0;
               s_nxt.pll_pend  = 1'b0;
            end
         endcase
      end else if (s_r.pll_pend && cp_event) begin
         // Gated by the pump so the loop never sees a frequency jump
         s_nxt.pll_pd_st = 1'b1;
         s_nxt.pll_pend  = 1'b0;
      end
      // Soft reset holds defaults for as long as the host leaves the bit set
      if (soft_rst) begin
         keep_port              = s_nxt.shadow.port_cfg;
         s_nxt.shadow           = CFG_DEFAULT;
         s_nxt.shadow.port_cfg  = keep_port;
         s_nxt.active           = CFG_DEFAULT;
         s_nxt.active.port_cfg  = s_r.active.port_cfg;
         s_nxt.pll_pd_st        = 1'b0;
         s_nxt.pll_pend         = 1'b0;
      end
      // Hard reset wins over everything, including a write in the same cycle
      if (fmode == FPIN_RESET && !func_pin) begin
         s_nxt.ps        = PS_HRST;
         s_nxt.shadow    = CFG_DEFAULT;
         s_nxt.active    = CFG_DEFAULT;
         s_nxt.pll_pd_st = 1'b0;
         s_nxt.pll_pend  = 1'b0;
      end else if (fmode == FPIN_SLEEP && !func_pin) begin
         s_nxt.ps = PS_SLEEP;
      end else begin
         s_nxt.ps = PS_RUN;
      end
      // Slow-edge coincidence detector; off while asleep with the sync circuits
      s_nxt.ref_d = slow_ref;
      s_nxt.fb_d  = slow_fb;
      if (!mcs_en || sleep_c) begin
         s_nxt.ref_wait = 1'b0;
         s_nxt.fb_wait  = 1'b0;
         s_nxt.oos      = 1'b0;
      end else if (ref_rise && fb_rise) begin
         s_nxt.ref_wait = 1'b0;
         s_nxt.fb_wait  = 1'b0;
         s_nxt.oos      = 1'b0;
      end else if (ref_rise) begin
         if (s_r.fb_wait) begin
            s_nxt.fb_wait = 1'b0;
            s_nxt.oos     = (s_r.fb_age >= tol);
         end else begin
            s_nxt.ref_wait = 1'b1;
            s_nxt.ref_age  = 2'h0;
         end
      end else if (fb_rise) begin
         if (s_r.ref_wait) begin
            s_nxt.ref_wait = 1'b0;
            s_nxt.oos      = (s_r.ref_age >= tol);
         end else begin
            s_nxt.fb_wait = 1'b1;
            s_nxt.fb_age  = 2'h0;
         end
      end else begin
         if (s_r.ref_wait) begin
            if (s_r.ref_age >= tol) begin
               s_nxt.ref_wait = 1'b0;
               s_nxt.oos      = 1'b1;
            end else begin
               s_nxt.ref_age = s_r.ref_age + 2'h1;
            end
         end
         if (s_r.fb_wait) begin
            if (s_r.fb_age >= tol) begin
               s_nxt.fb_wait = 1'b0;
               s_nxt.oos     = 1'b1;
            end else begin
               s_nxt.fb_age = s_r.fb_age + 2'h1;
            end
         end
      end
      // Registered outputs, built from the present state except status, which takes the next oos
      s_nxt.pwr.pll_pd       = sleep_c | s_r.pll_pd_st;
      s_nxt.pwr.dist_pd      = s_r.active.func_sync[BIT_DIST_PD];
      s_nxt.pwr.clocks_off   = sleep_c | hrst_c;
      s_nxt.pwr.dividers_off = sleep_c | hrst_c;
      s_nxt.pwr.sync_hold    = ~sleep_c & ((fmode == FPIN_SYNC && !func_pin)
                               | s_r.active.func_sync[BIT_SOFT_SYNC]
                               | soft_rst);
      s_nxt.pwr.lvds_off     = lvds_off_c;
      s_nxt.pwr.pecl_mode    = pecl_mode_c;
      s_nxt.status           = mcs_en & ~sleep_c & s_nxt.oos;
      s_nxt.status_oe        = mcs_en;
   end

   // State register; reset loads every default
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= TOP_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pwr        = s_r.pwr;
   assign status_out = s_r.status;
   assign status_oe  = s_r.status_oe;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_sleep_entry: assert property ((fmode == FPIN_SLEEP && !func_pin)
      |=> s_r.ps == PS_SLEEP ##1 (pwr.pll_pd && pwr.clocks_off))
      else $error("sleep not entered on low pin");
   a_sleep_state: assert property ((s_r.ps == PS_SLEEP)
      |=> (&pwr.lvds_off) && pwr.dividers_off && pwr.pecl_mode[0] == PECL_SAFE)
      else $error("sleep outputs wrong");
   a_sleep_keep: assert property ((s_r.ps == PS_SLEEP && !wr.en && !soft_rst
      && fmode == FPIN_SLEEP) |=> $stable(s_r.shadow) && $stable(s_r.active))
      else $error("registers lost in sleep");
   a_pll_async: assert property ((upd && !soft_rst && !(fmode == FPIN_RESET && !func_pin)
      && s_r.shadow.pll_pd[1:0] == PLL_PD_ASYNC) |=> ##1 pwr.pll_pd)
      else $error("async pll power-down late");
   a_pll_sync: assert property ((s_r.pll_pend && !upd && !soft_rst
      && !(fmode == FPIN_RESET && !func_pin))
      |-> if (cp_event) ##1 s_r.pll_pd_st else ##1 !s_r.pll_pd_st)
      else $error("sync pll power-down not tied to pump event");
   a_pll_normal: assert property ((upd && s_r.shadow.pll_pd[0] == 1'b0)
      |=> !s_r.pll_pd_st && !s_r.pll_pend)
      else $error("normal pll code powered down");
   a_hard_reset: assert property ((fmode == FPIN_RESET && !func_pin)
      |=> s_r.shadow == CFG_DEFAULT && s_r.active == CFG_DEFAULT && s_r.ps == PS_HRST)
      else $error("hard reset did not restore defaults");
   a_soft_reset: assert property ((soft_rst && !wr.en && !(fmode == FPIN_RESET && !func_pin))
      |=> s_r.active.pll_pd == RST_PLL_PD && s_r.shadow.func_sync == RST_FUNC_SYNC)
      else $error("soft reset left values");
   // A host write of zero may land one cycle later, so only the next cycle is bound
   a_soft_sticky: assert property ((soft_rst && !wr.en && !(fmode == FPIN_RESET && !func_pin))
      |=> soft_rst)
      else $error("soft reset bit cleared by device");
   a_sync_hold: assert property ((s_r.ps == PS_RUN && fmode == FPIN_SYNC && !func_pin)
      |=> pwr.sync_hold)
      else $error("sync input did not hold outputs");
   a_soft_sync: assert property ((s_r.ps == PS_RUN && !soft_rst && fmode != FPIN_SYNC)
      |=> pwr.sync_hold == $past(s_r.active.func_sync[BIT_SOFT_SYNC]))
      else $error("soft sync polarity wrong");
   a_flag_narrow: assert property ((mcs_en && s_r.ps == PS_RUN && tol == TOL_NARROW
      && ref_rise && !fb_rise && !s_r.fb_wait && !s_r.ref_wait) ##1 (!fb_rise && mcs_en)
      |=> s_r.oos ##1 status_out)
      else $error("narrow window missed a separation");
   a_status_oe: assert property (mcs_en |=> status_oe)
      else $error("status pin not driven with multichip sync on");
   a_update_read: assert property ((rd_addr == OFS_UPDATE) |-> rd_data == 8'h00)
      else $error("update bit does not read as cleared");

   c_sleep_wake: cover property ((s_r.ps == PS_SLEEP) ##1 (s_r.ps == PS_RUN));
   c_pll_sync:   cover property (s_r.pll_pend ##[1:20] s_r.pll_pd_st);
   c_oos_flag:   cover property (!status_out ##1 status_out);
   c_sync_pulse: cover property (!pwr.sync_hold ##1 pwr.sync_hold ##[1:20] !pwr.sync_hold);
endmodule
`default_nettype wire

// File: testbench/cdprs_host_model.sv
// Host model that writes configuration bytes over the serial port
`timescale 1ns/10ps
`default_nettype none
module cdprs_host_model (
   // Clock
   input  wire logic clock,
   // Serial pins
   output logic      sclk,
   output logic      csb_n,
   output logic      sdio_in
);
   // Idle frame: deselected, shift clock low
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio_in = 1'b0;
   end
   // One-byte write; two clocks per phase keep the edge detector safe
   task automatic wr(input logic [12:0] a, input logic [7:0] v);
      logic [23:0] f;
      f = {3'h0, a, v};
      @(posedge clock) csb_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_in <= f[i];
         repeat (2) @(posedge clock);
         sclk <= 1'b1;
         repeat (2) @(posedge clock);
         sclk <= 1'b0;
      end
      @(posedge clock) csb_n <= 1'b1;
      sdio_in <= ~f[0]; // Released line must not echo the last bit
      repeat (3) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// File: testbench/cdprs_top_tb.sv
// Self-checking bench of the power, reset and sync control
`timescale 1ns/10ps
`default_nettype none
module cdprs_top_tb;
   import cdprs_pkg::*;
   logic clock = 1'b0, rst = 1'b1, func_pin = 1'b1, cp_event = 1'b0;
   logic slow_ref = 1'b0, slow_fb = 1'b0, status_out, status_oe;
   wire logic sclk, csb_n, sdio_in;
   cdprs_pwr_s pwr;
   int miscompares = 0, checks = 0, cycles = 0, seed = 32'hBEF3, d;
   // Clock generator
   always #10 clock = ~clock;
   cdprs_host_model cdprs_host_model_inst (.clock(clock), .sclk(sclk), .csb_n(csb_n),
      .sdio_in(sdio_in));
   cdprs_top cdprs_top_inst (.clock(clock), .rst(rst), .func_pin(func_pin),
      .cp_event(cp_event), .slow_ref(slow_ref), .slow_fb(slow_fb), .sclk(sclk),
      .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(), .sdio_oe(), .sdo_out(), .sdo_oe(),
      .pwr(pwr), .status_out(status_out), .status_oe(status_oe));
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // Write a register, then apply it
   task automatic cfg(input logic [12:0] a, input logic [7:0] v);
      cdprs_host_model_inst.wr(a, v);
      cdprs_host_model_inst.wr(OFS_UPDATE, 8'h01);
      repeat (3) @(posedge clock);
   endtask
   // Slow clock pair with chosen skew, well under a quarter of the fast rate
   task automatic slow(input int k);
      slow_ref <= 1'b1;
      repeat (k) @(posedge clock);
      slow_fb <= 1'b1;
      repeat (6) @(posedge clock);
      slow_ref <= 1'b0;
      slow_fb <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, far above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      chk(pwr.clocks_off, 1'b0, "por");
      // Every PLL code; charge-pump event after a random wait
      for (int m = 0; m < 4; m++) begin
         cfg(OFS_PLL_PD, 8'(m));
         chk(pwr.pll_pd, 8'(m == 1), "pll pre");
         d = 1 + ($random(seed) & 7);
         repeat (d) @(posedge clock);
         cp_event <= 1'b1;
         @(posedge clock) cp_event <= 1'b0;
         repeat (2) @(posedge clock);
         chk(pwr.pll_pd, 8'(m & 1), "pll post");
      end
      // Sleep mode, with a write while asleep
      cfg(OFS_FUNC_SYNC, 8'h40);
      func_pin <= 1'b0;
      repeat (3) @(posedge clock);
      chk({pwr.clocks_off, pwr.dividers_off, pwr.lvds_off, pwr.pll_pd}, 8'h7F, "slp");
      chk(8'(pwr.pecl_mode), 8'hAA, "safe");
      cfg(OFS_PLL_PD, 8'h01);
      func_pin <= 1'b1;
      repeat (3) @(posedge clock);
      chk({pwr.clocks_off, pwr.pll_pd}, 8'h01, "wake");
      // Sync mode: soft sync with distribution off, then pin sync with distribution on
      cfg(OFS_FUNC_SYNC, 8'h2C);
      chk({pwr.dist_pd, pwr.sync_hold}, 8'h03, "ssync");
      cfg(OFS_FUNC_SYNC, 8'h20);
      func_pin <= 1'b0;
      repeat (3) @(posedge clock);
      chk({pwr.dist_pd, pwr.sync_hold}, 8'h01, "hsync");
      func_pin <= 1'b1;
      cfg(OFS_LVDS_PD0 + 13'h0002, 8'h01);
      cfg(OFS_PECL_PD0 + 13'h0001, 8'h03);
      chk({pwr.lvds_off, 2'h0, pwr.pecl_mode[1]}, 8'h43, "outs");
      // Multichip flag: skew and window table
      for (int t = 0; t < 5; t++) begin
         cfg(OFS_FUNC_SYNC, (t > 2) ? 8'h23 : 8'h21);
         slow((t == 1) ? 3 : (t == 4) ? 0 : t & 1);
         chk({status_oe, status_out}, {7'h01, (t == 1 || t == 3)}, "mcs");
         if (status_out) begin
            func_pin <= 1'b0;
            repeat (3) @(posedge clock);
            chk(pwr.sync_hold, 8'h01, "resync");
            func_pin <= 1'b1;
         end
      end
      // Soft reset holds until cleared, then defaults are seen
      cdprs_host_model_inst.wr(OFS_PORT_CFG, 8'h20);
      chk(pwr.sync_hold, 8'h01, "srst");
      cdprs_host_model_inst.wr(OFS_PORT_CFG, 8'h00);
      chk({status_oe, pwr.sync_hold}, 8'h00, "srst clr");
      // Hard reset from the pin in the default mode
      cfg(OFS_PLL_PD, 8'h01);
      func_pin <= 1'b0;
      repeat (3) @(posedge clock);
      func_pin <= 1'b1;
      repeat (4) @(posedge clock);
      chk(pwr.pll_pd, 8'h00, "hrst");
      end_of_test();
   end
endmodule
`default_nettype wire
